// File: common/ext_irq_map.vh
// register offsets, field positions, reset values and sense codes of the pin interrupt sense block
`ifndef EXT_IRQ_MAP_VH
`define EXT_IRQ_MAP_VH

`define ADDR_W              4
`define OFF_PIN_LOW_SENSE   4'h0
`define OFF_PIN_HIGH_SENSE  4'h1
`define OFF_GROUP_SENSE     4'h2
`define OFF_PIN_PENDING     4'h3
`define OFF_GROUP_PENDING   4'h4
`define OFF_PORT_SEL_LOW    4'h5
`define OFF_EXTRA_SENSE     4'hA
`define OFF_PORT_SEL_HIGH   4'hB
`define OFF_PIN_MASK        4'hC
`define OFF_GROUP_MASK      4'hD

`define RST_SENSE           8'h00
`define RST_PENDING         8'h00
`define RST_PORT_SEL        8'h00
`define RST_MASK            8'h00
`define RST_PIN_LEVEL       1'b1

`define EXTRA_SENSE_BITS    8'h0F
`define PORT_SEL_HIGH_BITS  8'h7F
`define GROUP_PEND_ALL      8'h3F
`define GROUP_PEND_SMALL    8'h0F

`define SENSE_FALL_LOW      2'h0
`define SENSE_RISE          2'h1
`define SENSE_FALL          2'h2
`define SENSE_BOTH          2'h3

`define GRP_B               0
`define GRP_D               1
`define GRP_E               2
`define GRP_F               3
`define GRP_G               4
`define GRP_H               5

`endif

// File: verilog/ext_irq_sense.v
// pin interrupt sense block: sensitivity registers, pin synchronisers, edge/level detect, pending flags
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "ext_irq_map.vh"

// Functional notes
// RULE_01: register 0x00 holds pin-bit 3..0 sense codes, two bits each, bit 3 on top.
// RULE_02: pin-bit 0 code covers ports A..F; pin-bit 1..7 codes cover ports A..E.
// RULE_03: register 0x01 holds pin-bit 7..4 sense codes, two bits each, bit 7 on top.
// RULE_04: register 0x02 holds group codes F,E,D,B from top; used when nibble routed.
// RULE_05: register 0x0A holds group H in 3:2, G in 1:0; upper bits reserved.
// RULE_06: sense fields take writes only while both cpu priority bits are one.
// RULE_07: code 00 falling plus low, 01 rising, 10 falling, 11 both edges.
// RULE_08: event on pin bit x of a covered port sets pending bit x at 0x03.
// RULE_09: writing one clears a pending flag; zero leaves it; one means pending.
// RULE_10: register 0x04 holds group pending flags B,D,E,F,G,H in bits 0..5.
// RULE_11: group G and H flags exist only on the larger variant; otherwise reserved.
// RULE_12: all sense and status registers read 0x00 after reset.
// RULE_13: a port-select bit routes a nibble to per-bit sources (0) or group source.
// RULE_14: a pin interrupts only when configured as input with interrupt enabled.
// RULE_15: priority level 3, both bits one, is the only unlocking state.
// RULE_16: pins pass a synchroniser; consecutive filtered samples reveal rising and falling edges.
// RULE_17: falling-plus-low code re-sets the flag every clock while the pin stays low.
module ext_irq_sense #(
  parameter HAS_GH = 1                          // 1: ports G and H present
) (
  input  wire        mclk,                      // 200 MHz clock
  input  wire        rst,                       // async reset, active high
  input  wire [3:0]  reg_addr,                  // register offset
  input  wire [7:0]  reg_wdata,                 // write data
  input  wire        reg_wr,                    // write strobe
  input  wire        reg_rd,                    // read strobe
  output reg  [7:0]  reg_rdata,                 // read data, cycle after strobe
  input  wire [63:0] pin_in,                    // port pins, port A in 7:0 .. port H in 63:56
  input  wire [63:0] pin_irq_en,                // pin is input with interrupt enabled
  input  wire        cpu_priority_high_bit,     // cpu condition flags priority bit 1
  input  wire        cpu_priority_low_bit,      // cpu condition flags priority bit 0
  output reg  [7:0]  pin_irq_req,               // per pin-bit requests, pending and unmasked
  output reg  [5:0]  group_irq_req,             // per group requests, pending and unmasked
  output reg         irq                        // any unmasked pending flag
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0]  pin_low_sense_ctrl_r;
  reg  [7:0]  pin_high_sense_ctrl_r;
  reg  [7:0]  port_group_sense_ctrl_r;
  reg  [7:0]  extra_port_sense_ctrl_r;
  reg  [7:0]  pin_pending_flags_r;
  reg  [7:0]  port_group_pending_flags_r;
  reg  [7:0]  port_sel_low_r;
  reg  [7:0]  port_sel_high_r;
  reg  [7:0]  pin_mask_r;
  reg  [7:0]  group_mask_r;
  reg  [7:0]  pin_pending_nxt;
  reg  [7:0]  group_pending_nxt;
  reg  [7:0]  rdata_nxt;

  wire [7:0]  extra_bits;
  wire [7:0]  sel_high_bits;
  wire [7:0]  group_valid;
  wire        sense_unlock;
  wire        wr_low;
  wire        wr_high;
  wire        wr_group;
  wire        wr_extra;
  wire        wr_pin_pend;
  wire        wr_group_pend;
  wire        wr_sel_low;
  wire        wr_sel_high;
  wire        wr_pin_mask;
  wire        wr_group_mask;

  wire [7:0]  pin_req_nxt;
  wire [5:0]  group_req_nxt;

  assign extra_bits    = (HAS_GH != 0) ? `EXTRA_SENSE_BITS : 8'h00;     // [RULE_05]
  assign sel_high_bits = (HAS_GH != 0) ? `PORT_SEL_HIGH_BITS : 8'h00;
  assign group_valid   = (HAS_GH != 0) ? `GROUP_PEND_ALL : `GROUP_PEND_SMALL; // [RULE_11]

  // only level 3 opens the sense fields; other writes drop silently
  assign sense_unlock  = cpu_priority_high_bit & cpu_priority_low_bit; // [RULE_15]
  assign wr_low        = reg_wr & sense_unlock & (reg_addr == `OFF_PIN_LOW_SENSE);  // [RULE_06]
  assign wr_high       = reg_wr & sense_unlock & (reg_addr == `OFF_PIN_HIGH_SENSE); // [RULE_06]
  assign wr_group      = reg_wr & sense_unlock & (reg_addr == `OFF_GROUP_SENSE);    // [RULE_06]
  assign wr_extra      = reg_wr & sense_unlock & (reg_addr == `OFF_EXTRA_SENSE);    // [RULE_06]
  assign wr_pin_pend   = reg_wr & (reg_addr == `OFF_PIN_PENDING);
  assign wr_group_pend = reg_wr & (reg_addr == `OFF_GROUP_PENDING);
  // routing and masks stay open at any priority level
  assign wr_sel_low    = reg_wr & (reg_addr == `OFF_PORT_SEL_LOW);
  assign wr_sel_high   = reg_wr & (reg_addr == `OFF_PORT_SEL_HIGH);
  assign wr_pin_mask   = reg_wr & (reg_addr == `OFF_PIN_MASK);
  assign wr_group_mask = reg_wr & (reg_addr == `OFF_GROUP_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // nibble routing: bit 2p is low nibble of port p, 2p+1 its high nibble
  wire [15:0] nib_grp;

  assign nib_grp[1:0]   = 2'b00;                                // port A: per-bit only
  assign nib_grp[3:2]   = port_sel_low_r[1:0];                  // port B [RULE_13]
  assign nib_grp[5:4]   = 2'b00;                                // port C: per-bit only
  assign nib_grp[7:6]   = port_sel_low_r[3:2];                  // port D [RULE_13]
  assign nib_grp[9:8]   = port_sel_low_r[5:4];                  // port E [RULE_13]
  assign nib_grp[11:10] = {port_sel_high_r[0], port_sel_low_r[6]}; // port F [RULE_13]
  assign nib_grp[13:12] = port_sel_high_r[2:1];                 // port G [RULE_13]
  assign nib_grp[15:14] = port_sel_high_r[4:3];                 // port H [RULE_13]

  ////////////////////////////////////////////////////////////////////////////
  // per-pin synchroniser and event detect
  wire [63:0] pin_evt;
  wire [63:0] bit_route;
  wire [63:0] grp_route;

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi = gi + 1) begin : g_pin
      localparam PORT = gi / 8;
      localparam BITN = gi % 8;
      // port index to group slot; ports A and C have none
      localparam GSLOT = (PORT == 1) ? `GRP_B : (PORT == 3) ? `GRP_D : (PORT == 4) ? `GRP_E :
                         (PORT == 5) ? `GRP_F : (PORT == 6) ? `GRP_G : (PORT == 7) ? `GRP_H : 0;
      localparam HAS_GRP = (PORT == 1) || (PORT == 3) || (PORT >= 4);
      localparam IN_BITS = (PORT <= 4) || ((PORT == 5) && (BITN == 0));      // [RULE_02]
      localparam PRESENT = (PORT < 6) || (HAS_GH != 0);

      reg        s1_r;
      reg        s2_r;
      reg        s3_r;
      reg        lvl_r;
      reg  [1:0] code;
      wire       grp_sel;
      wire       agree;
      wire       rise;
      wire       fall;
      reg        hit;

      // third stage only confirms: a level counts once stages two and three match
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          s1_r  <= `RST_PIN_LEVEL;
          s2_r  <= `RST_PIN_LEVEL;
          s3_r  <= `RST_PIN_LEVEL;
          lvl_r <= `RST_PIN_LEVEL;
        end else begin
          s1_r  <= pin_in[gi];
          s2_r  <= s1_r;
          s3_r  <= s2_r;
          if (agree) begin
            lvl_r <= s3_r;                      // [RULE_16]
          end
        end
      end

      assign agree   = (s2_r == s3_r);
      assign rise    = agree & s3_r & ~lvl_r;   // [RULE_16]
      assign fall    = agree & ~s3_r & lvl_r;   // [RULE_16]
      assign grp_sel = HAS_GRP ? nib_grp[PORT * 2 + BITN / 4] : 1'b0;

      always @* begin
        code = `SENSE_FALL_LOW;
        if (grp_sel) begin
          case (GSLOT)
            `GRP_B:  code = port_group_sense_ctrl_r[1:0];     // [RULE_04]
            `GRP_D:  code = port_group_sense_ctrl_r[3:2];     // [RULE_04]
            `GRP_E:  code = port_group_sense_ctrl_r[5:4];     // [RULE_04]
            `GRP_F:  code = port_group_sense_ctrl_r[7:6];     // [RULE_04]
            `GRP_G:  code = extra_port_sense_ctrl_r[1:0];     // [RULE_05]
            `GRP_H:  code = extra_port_sense_ctrl_r[3:2];     // [RULE_05]
            default: code = `SENSE_FALL_LOW;
          endcase
        end else if (BITN < 4) begin
          code = pin_low_sense_ctrl_r[BITN * 2 +: 2];         // [RULE_01]
        end else begin
          code = pin_high_sense_ctrl_r[(BITN - 4) * 2 +: 2];  // [RULE_03]
        end
      end

      // a held low keeps firing, so a clear only sticks once the pin goes high
      always @* begin
        case (code)
          `SENSE_FALL_LOW: hit = fall | ~lvl_r;               // [RULE_07] [RULE_17]
          `SENSE_RISE:     hit = rise;                        // [RULE_07]
          `SENSE_FALL:     hit = fall;                        // [RULE_07]
          `SENSE_BOTH:     hit = rise | fall;                 // [RULE_07]
          default:         hit = 1'b0;
        endcase
      end

      assign pin_evt[gi]   = hit & pin_irq_en[gi] & (PRESENT != 0);   // [RULE_14]
      assign bit_route[gi] = (IN_BITS != 0) & ~grp_sel;               // [RULE_02] [RULE_13]
      assign grp_route[gi] = grp_sel;                                 // [RULE_13]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // collect events into pin-bit and group sets
  reg  [7:0] pin_set;
  reg  [7:0] group_set;
  wire [5:0] group_hit;
  integer    p;
  integer    b;

  // one slot per group: OR over the pins of the owning port routed to it
  genvar gg;
  generate
    for (gg = 0; gg < 6; gg = gg + 1) begin : g_grp
      localparam BASE = (gg == `GRP_B) ? 8 : (gg == `GRP_D) ? 24 : (gg == `GRP_E) ? 32 :
                        (gg == `GRP_F) ? 40 : (gg == `GRP_G) ? 48 : 56;
      assign group_hit[gg] = |(pin_evt[BASE +: 8] & grp_route[BASE +: 8]);   // [RULE_10]
    end
  endgenerate

  always @* begin
    pin_set   = 8'h00;
    group_set = 8'h00;
    for (p = 0; p < 8; p = p + 1) begin
      for (b = 0; b < 8; b = b + 1) begin
        if (pin_evt[p * 8 + b] & bit_route[p * 8 + b]) begin
          pin_set[b] = 1'b1;                                  // [RULE_08]
        end
      end
    end
    group_set = {2'b00, group_hit} & group_valid;             // [RULE_11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending flags: a new event outranks a clear in the same cycle
  always @* begin
    pin_pending_nxt   = pin_pending_flags_r;
    group_pending_nxt = port_group_pending_flags_r;
    if (wr_pin_pend) begin
      pin_pending_nxt = pin_pending_nxt & ~reg_wdata;         // [RULE_09]
    end
    if (wr_group_pend) begin
      group_pending_nxt = group_pending_nxt & ~reg_wdata;     // [RULE_09]
    end
    pin_pending_nxt   = pin_pending_nxt | pin_set;            // [RULE_08]
    group_pending_nxt = (group_pending_nxt | group_set) & group_valid; // [RULE_10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  always @* begin
    case (reg_addr)
      `OFF_PIN_LOW_SENSE:  rdata_nxt = pin_low_sense_ctrl_r;
      `OFF_PIN_HIGH_SENSE: rdata_nxt = pin_high_sense_ctrl_r;
      `OFF_GROUP_SENSE:    rdata_nxt = port_group_sense_ctrl_r;
      `OFF_PIN_PENDING:    rdata_nxt = pin_pending_flags_r;           // [RULE_09]
      `OFF_GROUP_PENDING:  rdata_nxt = port_group_pending_flags_r;    // [RULE_09]
      `OFF_PORT_SEL_LOW:   rdata_nxt = port_sel_low_r;
      `OFF_EXTRA_SENSE:    rdata_nxt = extra_port_sense_ctrl_r;       // [RULE_05]
      `OFF_PORT_SEL_HIGH:  rdata_nxt = port_sel_high_r;
      `OFF_PIN_MASK:       rdata_nxt = pin_mask_r;
      `OFF_GROUP_MASK:     rdata_nxt = group_mask_r;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // unmasked requests, registered below so every output leaves a flop
  assign pin_req_nxt   = pin_pending_flags_r & pin_mask_r;
  assign group_req_nxt = port_group_pending_flags_r[5:0] & group_mask_r[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // sensitivity registers: writes land only at level 3
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_low_sense_ctrl_r    <= `RST_SENSE;    // [RULE_12]
      pin_high_sense_ctrl_r   <= `RST_SENSE;    // [RULE_12]
      port_group_sense_ctrl_r <= `RST_SENSE;    // [RULE_12]
      extra_port_sense_ctrl_r <= `RST_SENSE;    // [RULE_12]
    end else begin
      if (wr_low) begin
        pin_low_sense_ctrl_r <= reg_wdata;          // [RULE_01]
      end
      if (wr_high) begin
        pin_high_sense_ctrl_r <= reg_wdata;         // [RULE_03]
      end
      if (wr_group) begin
        port_group_sense_ctrl_r <= reg_wdata;       // [RULE_04]
      end
      if (wr_extra) begin
        extra_port_sense_ctrl_r <= reg_wdata & extra_bits;   // [RULE_05]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing and mask registers; 0x05 bit 7 and 0x0B bits 6:5 are stored only,
  // they steer vectors outside this block and never touch a flag
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_sel_low_r  <= `RST_PORT_SEL;
      port_sel_high_r <= `RST_PORT_SEL;
      // all masked after reset, so a fresh part stays quiet until software opts in
      pin_mask_r      <= `RST_MASK;
      group_mask_r    <= `RST_MASK;
    end else begin
      if (wr_sel_low) begin
        port_sel_low_r <= reg_wdata;
      end
      if (wr_sel_high) begin
        port_sel_high_r <= reg_wdata & sel_high_bits;
      end
      if (wr_pin_mask) begin
        pin_mask_r <= reg_wdata;
      end
      if (wr_group_mask) begin
        group_mask_r <= reg_wdata & group_valid;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending flags
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_pending_flags_r        <= `RST_PENDING;   // [RULE_12]
      port_group_pending_flags_r <= `RST_PENDING;   // [RULE_12]
    end else begin
      pin_pending_flags_r        <= pin_pending_nxt;
      port_group_pending_flags_r <= group_pending_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata     <= 8'h00;
      pin_irq_req   <= 8'h00;
      group_irq_req <= 6'h00;
      irq           <= 1'b0;
    end else begin
      // read data live only in the cycle after the strobe
      reg_rdata     <= reg_rd ? rdata_nxt : 8'h00;
      // requests follow the flags one cycle late, trading a cycle for flop outputs
      pin_irq_req   <= pin_req_nxt;
      group_irq_req <= group_req_nxt;
      irq           <= |{pin_req_nxt, group_req_nxt};
    end
  end

endmodule // ext_irq_sense

// File: tb/pin_bank_model.sv
// port pin and cpu priority model facing the pin interrupt sense block
`timescale 1ns/1ps
module pin_bank_model (
  input  wire        mclk,       // clock
  output reg  [63:0] pin_in,     // pin levels
  output reg  [63:0] pin_irq_en, // input with interrupt enabled
  output reg         prio_hi,    // cpu priority bit 1
  output reg         prio_lo     // cpu priority bit 0
);
  initial begin
    pin_in = 64'hFFFF_FFFF_FFFF_FFFF; // pull-ups keep idle pins high
    pin_irq_en = 64'h0;
    prio_hi = 1'b1;
    prio_lo = 1'b0;
  end
  task set_bits(input integer lsb, input [3:0] v);
    begin
      @(posedge mclk);
      pin_in[lsb +: 4] <= v;
    end
  endtask
  task set_en(input [63:0] m);
    begin
      @(posedge mclk);
      pin_irq_en <= m;
    end
  endtask
  task set_prio(input [1:0] p);
    begin
      @(posedge mclk);
      {prio_hi, prio_lo} <= p;
    end
  endtask
endmodule // pin_bank_model

// File: tb/ext_irq_sense_monitor.sv
// port assertions for the pin interrupt sense block
`timescale 1ns/1ps
module ext_irq_sense_monitor #(
  parameter HAS_GH = 1 // ports G and H present
) (
  input wire       mclk,          // clock
  input wire       rst,           // reset
  input wire [3:0] reg_addr,      // register offset
  input wire       reg_rd,        // read strobe
  input wire [7:0] reg_rdata,     // read data
  input wire [7:0] pin_irq_req,   // pin-bit requests
  input wire [5:0] group_irq_req, // group requests
  input wire       irq            // interrupt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_rd_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside read slot");
  chk_grp_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == 4'h4 |-> reg_rdata[7:6] == 2'b00)
    else $error("group pending reserved bits set");
  chk_extra_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == 4'hA |-> reg_rdata[7:4] == 4'h0)
    else $error("extra sense reserved bits set");
  chk_pin_req_flag: assert property ($past(reg_rd) && $past(reg_addr) == 4'h3 |->
    (pin_irq_req & ~reg_rdata) == 8'h00) else $error("pin request without pending flag");
  chk_grp_req_flag: assert property ($past(reg_rd) && $past(reg_addr) == 4'h4 |->
    (group_irq_req & ~reg_rdata[5:0]) == 6'h00) else $error("group request without pending flag");
  chk_irq_any_req: assert property (irq == (|pin_irq_req || |group_irq_req))
    else $error("interrupt disagrees with requests");
  chk_gh_absent: assert property (HAS_GH != 0 || group_irq_req[5:4] == 2'b00)
    else $error("absent group request raised");
  chk_reset_quiet: assert property ($fell(rst) |-> !irq && reg_rdata == 8'h00 && group_irq_req == 6'h00)
    else $error("outputs active after reset");
  cover property ($rose(irq));
  cover property (group_irq_req != 6'h00);
  cover property ($past(reg_rd) && reg_rdata != 8'h00);
endmodule // ext_irq_sense_monitor
bind ext_irq_sense ext_irq_sense_monitor #(.HAS_GH(HAS_GH)) u_mon (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_irq_req(pin_irq_req), .group_irq_req(group_irq_req), .irq(irq));

// File: tb/tb.sv
// self-checking testbench for the pin interrupt sense block
`timescale 1ns/1ps
module tb;
  reg         mclk;
  reg         rst;
  reg  [3:0]  reg_addr;
  reg  [7:0]  reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [7:0]  reg_rdata;
  wire [63:0] pin_in;
  wire [63:0] pin_irq_en;
  wire        prio_hi;
  wire        prio_lo;
  wire [7:0]  pin_irq_req;
  wire [5:0]  group_irq_req;
  wire        irq;
  integer     fail_count;
  integer     checked;
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  ext_irq_sense #(.HAS_GH(1)) u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_irq_en(pin_irq_en),
    .cpu_priority_high_bit(prio_hi), .cpu_priority_low_bit(prio_lo), .pin_irq_req(pin_irq_req),
    .group_irq_req(group_irq_req), .irq(irq));
  pin_bank_model u_pins (.mclk(mclk), .pin_in(pin_in), .pin_irq_en(pin_irq_en), .prio_hi(prio_hi), .prio_lo(prio_lo));
  ////////////////////////////////////////////////////////////////
  task chk(input [127:0] what, input [7:0] exp, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk("register read", exp, reg_rdata);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    integer i;
    for (i = 0; i < 16; i = i + 1) rd(i[3:0], 8'h00);
  endtask
  task t_lock;
    integer i;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        u_pins.set_prio(i[1:0]);
        wr(4'h0, 8'hE4);
        rd(4'h0, 8'h00);
      end
      u_pins.set_prio(2'b11);
      wr(4'h0, 8'hE4);
      rd(4'h0, 8'hE4);
      wr(4'h1, 8'h1B);
      rd(4'h1, 8'h1B);
      wr(4'h2, 8'h02);
      rd(4'h2, 8'h02);
      wr(4'hA, 8'hF8);
      rd(4'hA, 8'h08);
    end
  endtask
  // port B bits 3..0 carry codes 11,10,01,00
  task t_edges;
    begin
      u_pins.set_en(64'h0000_0000_0000_FF00);
      u_pins.set_bits(8, 4'h0);
      cyc(8);
      rd(4'h3, 8'h0D);
      wr(4'h3, 8'hFF);
      cyc(2);
      rd(4'h3, 8'h01);
      u_pins.set_bits(8, 4'hF);
      cyc(8);
      wr(4'h3, 8'h01);
      rd(4'h3, 8'h0A);
      wr(4'hC, 8'h08);
      cyc(2);
      #1 chk("pin request", 8'h08, pin_irq_req);
      chk("irq masked in", 8'h01, {7'h00, irq});
      wr(4'hC, 8'h00);
      cyc(2);
      #1 chk("irq masked out", 8'h00, {7'h00, irq});
      wr(4'h3, 8'hFF);
      wr(4'hC, 8'h08);
      cyc(2);
      #1 chk("irq cleared", 8'h00, {7'h00, irq});
    end
  endtask
  task t_route;
    begin
      u_pins.set_en(64'h0);
      u_pins.set_bits(24, 4'h0);
      cyc(8);
      rd(4'h3, 8'h00);
      u_pins.set_en(64'h0000_0000_FF00_0000);
      cyc(8);
      rd(4'h3, 8'h01);
      u_pins.set_bits(24, 4'hF);
      u_pins.set_en(64'h0000_FF00_0000_0000);
      wr(4'h3, 8'hFF);
      u_pins.set_bits(40, 4'hA);
      cyc(8);
      rd(4'h3, 8'h01);
      u_pins.set_bits(40, 4'hF);
      cyc(8);
      wr(4'h3, 8'hFF);
    end
  endtask
  task t_group;
    begin
      u_pins.set_en(64'hFF00_0000_0000_FF00);
      wr(4'h5, 8'h01);
      wr(4'hB, 8'h08);
      u_pins.set_bits(8, 4'hE);
      u_pins.set_bits(56, 4'hE);
      cyc(8);
      rd(4'h4, 8'h21);
      rd(4'h3, 8'h00);
      wr(4'hD, 8'h20);
      cyc(2);
      #1 chk("group request", 8'h20, {2'b00, group_irq_req});
      wr(4'h4, 8'h20);
      rd(4'h4, 8'h01);
      cyc(2);
      #1 chk("irq after clear", 8'h00, {7'h00, irq});
    end
  endtask
  // remaining ports: A, C, E, G and the high nibbles
  task t_ports;
    begin
      u_pins.set_en(64'hFFFF_FFFF_FFFF_FFFF);
      u_pins.set_bits(8, 4'hF);
      u_pins.set_bits(56, 4'hF);
      u_pins.set_bits(4, 4'h0);
      cyc(8);
      wr(4'h4, 8'hFF);
      rd(4'h3, 8'hB0);
      u_pins.set_bits(4, 4'hF);
      cyc(8);
      rd(4'h3, 8'hF0);
      wr(4'h3, 8'hFF);
      wr(4'h5, 8'h21);
      wr(4'hB, 8'h0C);
      u_pins.set_bits(36, 4'h7);
      u_pins.set_bits(52, 4'hB);
      u_pins.set_bits(16, 4'hE);
      u_pins.set_bits(44, 4'h7);
      cyc(8);
      rd(4'h4, 8'h14);
      rd(4'h3, 8'h01);
      u_pins.set_bits(36, 4'hF);
      u_pins.set_bits(52, 4'hF);
      u_pins.set_bits(16, 4'hF);
      u_pins.set_bits(44, 4'hF);
      cyc(8);
      wr(4'h3, 8'hFF);
      wr(4'h4, 8'hFF);
      rd(4'h3, 8'h00);
      rd(4'h4, 8'h00);
      u_pins.set_prio(2'b00);
      wr(4'hA, 8'h00);
      rd(4'hA, 8'h08);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    fail_count = 0;
    checked = 0;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cyc(12);
    rst <= 1'b0;
    t_reset;
    t_lock;
    t_edges;
    t_route;
    t_group;
    t_ports;
    // second reset with live state: every register must drop back
    @(posedge mclk);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    t_reset;
    finish_test;
  end
  // about 310 cycles expected; far margin before cutting a hang
  initial begin
    #20000;
    fail_count = fail_count + 1;
    finish_test;
  end
endmodule // tb
